// ### rtl/rbac_bank.sv
// register bit access bank: four 16-bit words of access cells behind an
// arbiter shared by four host access sources
// assumes every source drives req/we/addr/wdata from logic on clk and holds
// them until its ack; serial protocol decoders sit outside this block
//
// Operation
// - read-only bits return their value; writes leave them unchanged.
// - clear-on-read bits return the held value, then clear; writes ignored.
// - write-only bits accept writes; reads return zero.
// - write-one-clear bits clear on a written one; zero leaves them.
// - write-zero-clear bits clear on a written zero; one leaves them.
// - latch-low bits stay low after the condition recovers until read.
// - latch-high bits stay high after the condition goes until read.
// - self-clearing bits return to zero alone after a written one.
// - serial, two-wire and in-band ports all get full access to every word but the reserved one.
// - transceiver words are also reachable through the management port.
`timescale 1ns/1ps
module rbac_bank
    import rbac_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [NS-1:0]           req,
    input  wire logic [NS-1:0]           we,
    input  wire logic [NS-1:0][AW-1:0]   addr,
    input  wire logic [NS-1:0][DW-1:0]   wdata,
    input  wire logic [NW-1:0][DW-1:0]   hw_in,
    output logic      [NS-1:0]           ack,
    output logic      [DW-1:0]           rdata,
    output logic                         refused,
    output logic      [NW-1:0][DW-1:0]   cell_q
);

    logic [1:0]            rst_pipe;
    logic                  rst_n;
    rbac_state_t           state;
    rbac_state_t           next_state;
    logic [1:0]            sel;
    logic [1:0]            next_sel;
    logic [DW-1:0]         next_rdata;
    logic                  next_refused;
    logic [AW-1:0]         acc_addr;
    logic                  acc_we;
    logic [DW-1:0]         acc_wdata;
    logic                  hit;
    logic [NW-1:0]         word_rd;
    logic [NW-1:0]         word_wr;
    logic [NW-1:0][DW-1:0] word_rbits;

    // the reset edge is async, its release is taken through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // fixed priority: lowest source index first
    function automatic logic [1:0] rbac_pick(input logic [NS-1:0] r);
        logic [1:0] p;
        p = 2'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (r[i]) p = 2'(i);
        end
        return p;
    endfunction : rbac_pick

    // the management port sees only the transceiver words; nobody may
    // touch the reserved word, so a stray access cannot disturb state
    function automatic logic rbac_allowed(input logic [1:0] s,
                                          input logic [AW-1:0] a);
        return (a != W_RSVD) && ((s != 2'(S_PHY)) || (a >= PHY_LO));
    endfunction : rbac_allowed

    assign acc_addr  = addr[sel];
    assign acc_we    = we[sel];
    assign acc_wdata = wdata[sel];
    assign hit       = rbac_allowed(sel, acc_addr);

    always_comb begin
        next_state   = state;
        next_sel     = sel;
        next_rdata   = rdata;
        next_refused = refused;
        case (state)
            ST_IDLE: begin
                if (|req) begin
                    next_sel   = rbac_pick(req);
                    next_state = ST_ACC;
                end
            end
            ST_ACC: begin
                // read data is the value before any read side effect
                next_rdata   = (hit && !acc_we) ? word_rbits[acc_addr] : '0;
                next_refused = ~hit;
                next_state   = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            sel     <= 2'h0;
            rdata   <= 16'h0000;
            refused <= 1'b0;
        end else begin
            state   <= next_state;
            sel     <= next_sel;
            rdata   <= next_rdata;
            refused <= next_refused;
        end
    end

    // one acknowledge, to the source that was granted, during ST_DONE
    assign ack = (state == ST_DONE) ? (NS'(1) << sel) : '0;

    genvar w;
    genvar b;
    generate
        for (w = 0; w < NW; w++) begin : g_word
            assign word_rd[w] = (state == ST_ACC) && hit && !acc_we
                              && (acc_addr == AW'(w));
            assign word_wr[w] = (state == ST_ACC) && hit && acc_we
                              && (acc_addr == AW'(w));
            for (b = 0; b < DW; b++) begin : g_bit
                rbac_cell #(
                    .KIND (rbac_kind_of(w, b))
                ) u_cell (
                    .clk   (clk),
                    .rst_n (rst_n),
                    .rd    (word_rd[w]),
                    .wr    (word_wr[w]),
                    .wbit  (acc_wdata[b]),
                    .hw_in (hw_in[w][b]),
                    .q     (cell_q[w][b]),
                    .rbit  (word_rbits[w][b])
                );
            end
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ro_track_a: assert property (
        word_wr[W_STAT] |=> cell_q[W_STAT] == $past(hw_in[W_STAT]))
        else $error("read-only word changed by a write");

    rdclr_clear_a: assert property (
        word_rd[W_EVT] && !hw_in[W_EVT][F_RDCLR]
        |=> !cell_q[W_EVT][F_RDCLR] ##1 state == ST_IDLE)
        else $error("clear-on-read bit survived its read");

    rdclr_nowrite_a: assert property (
        word_wr[W_EVT] && !$past(word_rd[W_EVT])
        |=> cell_q[W_EVT][F_RDCLR+3:F_RDCLR] ==
            ($past(cell_q[W_EVT][F_RDCLR+3:F_RDCLR])
             | $past(hw_in[W_EVT][F_RDCLR+3:F_RDCLR])))
        else $error("write altered a clear-on-read bit");

    wo_read_a: assert property (
        state == ST_ACC && hit && !acc_we && acc_addr == W_LINK
        |=> rdata[F_WRONLY+3:F_WRONLY] == 4'h0 && ack != '0)
        else $error("write-only field read back nonzero");

    w1_clear_a: assert property (
        word_wr[W_EVT] && acc_wdata[F_W1CLR] && !hw_in[W_EVT][F_W1CLR]
        |=> !cell_q[W_EVT][F_W1CLR])
        else $error("write-one-clear bit kept after a one");

    w1_keep_a: assert property (
        word_wr[W_EVT] && !acc_wdata[F_W1CLR] && cell_q[W_EVT][F_W1CLR]
        |=> cell_q[W_EVT][F_W1CLR])
        else $error("write-one-clear bit lost on a zero");

    w0_clear_a: assert property (
        word_wr[W_EVT] && !acc_wdata[F_W0CLR] && !hw_in[W_EVT][F_W0CLR]
        |=> !cell_q[W_EVT][F_W0CLR])
        else $error("write-zero-clear bit kept after a zero");

    w0_keep_a: assert property (
        word_wr[W_EVT] && acc_wdata[F_W0CLR] && cell_q[W_EVT][F_W0CLR]
        |=> cell_q[W_EVT][F_W0CLR])
        else $error("write-zero-clear bit lost on a one");

    // the reset value is low although no condition drove it, so skip that cycle
    latlo_hold_a: assert property (
        $past(rst_n) && !cell_q[W_LINK][F_LATLO] && !word_rd[W_LINK]
        |=> !cell_q[W_LINK][F_LATLO])
        else $error("latch-low bit released without a read");

    lathi_hold_a: assert property (
        cell_q[W_LINK][F_LATHI] && !word_rd[W_LINK]
        |=> cell_q[W_LINK][F_LATHI])
        else $error("latch-high bit released without a read");

    self_clr_a: assert property (
        word_wr[W_EVT] && acc_wdata[F_SELF]
        |=> cell_q[W_EVT][F_SELF] ##1 !cell_q[W_EVT][F_SELF])
        else $error("self-clearing bit did not pulse once");

    grant_ack_a: assert property (
        state == ST_IDLE && |req
        |=> state == ST_ACC ##1 ack == ($past(req, 2) & (~$past(req, 2) + NS'(1))))
        else $error("request not acknowledged two cycles later");

    phy_limit_a: assert property (
        state == ST_ACC && sel == 2'(S_PHY) && acc_addr < PHY_LO
        |-> word_wr == '0 && word_rd == '0 ##1 refused)
        else $error("management port reached a switch word");

    rst_clear_a: assert property (
        $rose(rst_n) |-> cell_q[W_EVT] == 16'h0000 && state == ST_IDLE)
        else $error("event word not zero after reset");

    rdclr_read_c: cover property (word_rd[W_EVT] && cell_q[W_EVT][F_RDCLR]);
    latlo_c:    cover property (!cell_q[W_LINK][F_LATLO] && hw_in[W_LINK][F_LATLO]
                                && word_rd[W_LINK]);
    self_clr_c: cover property (word_wr[W_EVT] && acc_wdata[F_SELF]);
    phy_ref_c:  cover property (state == ST_DONE && refused && sel == 2'(S_PHY));
    contend_c:  cover property (state == ST_IDLE && req[S_SPI] && req[S_INB]);

endmodule : rbac_bank

// ### rtl/rbac_pkg.sv
// register bit access cells: shared widths, word map, cell kinds, states
// assumes one system clock; all access ports run on that clock
package rbac_pkg;

    localparam int DW = 16;             // one register word
    localparam int NW = 4;              // words in the bank
    localparam int NS = 4;              // access sources
    localparam int AW = 2;              // word address width
    localparam int F_W = 4;             // width of one field

    // word indices
    localparam logic [AW-1:0] W_STAT = 2'h0;
    localparam logic [AW-1:0] W_EVT  = 2'h1;
    localparam logic [AW-1:0] W_LINK = 2'h2;
    localparam logic [AW-1:0] W_RSVD = 2'h3;
    // lowest word the transceiver management port may reach
    localparam logic [AW-1:0] PHY_LO = 2'h2;

    // field lsbs in the event word
    localparam int F_RDCLR  = 0;
    localparam int F_W1CLR  = 4;
    localparam int F_W0CLR  = 8;
    localparam int F_SELF   = 12;
    // field lsbs in the link word
    localparam int F_LATLO  = 0;
    localparam int F_LATHI  = 4;
    localparam int F_CTRL   = 8;
    localparam int F_WRONLY = 12;

    // access sources, lowest index wins
    localparam int S_SPI = 0;
    localparam int S_TWI = 1;
    localparam int S_INB = 2;
    localparam int S_PHY = 3;

    localparam logic RST_BIT = 1'b0;

    typedef enum logic [3:0] {
        K_RDONLY, K_RDWR, K_RDCLR, K_WRONLY, K_W1CLR,
        K_W0CLR, K_LATLO, K_LATHI, K_SELFCLR, K_RSVD
    } rbac_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACC  = 3'b010,
        ST_DONE = 3'b100
    } rbac_state_t;

    function automatic rbac_kind_t rbac_kind_of(input int w, input int b);
        rbac_kind_t k;
        k = K_RSVD;
        if (w == int'(W_STAT)) begin
            k = K_RDONLY;
        end else if (w == int'(W_EVT)) begin
            case (b / F_W)
                0:       k = K_RDCLR;
                1:       k = K_W1CLR;
                2:       k = K_W0CLR;
                default: k = K_SELFCLR;
            endcase
        end else if (w == int'(W_LINK)) begin
            case (b / F_W)
                0:       k = K_LATLO;
                1:       k = K_LATHI;
                2:       k = K_RDWR;
                default: k = K_WRONLY;
            endcase
        end
        return k;
    endfunction : rbac_kind_of

endpackage : rbac_pkg

// ### rtl/rbac_cell.sv
// one register bit whose access behaviour is chosen by KIND
// assumes rd and wr are single-cycle strobes from the bank on clk
`timescale 1ns/1ps
module rbac_cell
    import rbac_pkg::*;
#(
    parameter rbac_kind_t KIND = K_RDWR
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic rd,
    input  wire logic wr,
    input  wire logic wbit,
    input  wire logic hw_in,
    output logic      q,
    output logic      rbit
);

    logic val;
    logic lat;
    logic next_val;
    logic next_lat;

    always_comb begin
        next_val = val;
        next_lat = lat;
        case (KIND)
            K_RDONLY:  next_val = hw_in;
            K_RDWR,
            K_WRONLY:  if (wr) next_val = wbit;
            // hardware set beats the clear in the same cycle
            K_RDCLR:   next_val = hw_in | (val & ~rd);
            K_W1CLR:   next_val = hw_in | (val & ~(wr & wbit));
            K_W0CLR:   next_val = hw_in | (val & ~(wr & ~wbit));
            K_LATLO: begin
                next_lat = ~hw_in | (lat & ~rd);
                next_val = hw_in & ~next_lat;
            end
            K_LATHI: begin
                next_lat = hw_in | (lat & ~rd);
                next_val = next_lat;
            end
            K_SELFCLR: next_val = wr & wbit;
            default:   next_val = RST_BIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            val <= RST_BIT;
            lat <= RST_BIT;
        end else begin
            val <= next_val;
            lat <= next_lat;
        end
    end

    assign q    = val;
    // write-only and reserved bits read as zero
    assign rbit = (KIND == K_WRONLY || KIND == K_RSVD) ? 1'b0 : val;

endmodule : rbac_cell

// ### tb/rbac_bank_tb_top.sv
// self-checking bench for the register bit access bank, one task per scenario
// assumes the bank answers two cycles after taking a request and that
// sources drop req at the edge that ends the ack cycle
`timescale 1ns/1ps
module rbac_bank_tb_top;
    import rbac_pkg::*;
    logic                  clk;
    logic                  resetn;
    logic [NS-1:0]         req;
    logic [NS-1:0]         we;
    logic [NS-1:0][AW-1:0] addr;
    logic [NS-1:0][DW-1:0] wdata;
    logic [NW-1:0][DW-1:0] hw_in;
    logic [NS-1:0]         ack;
    logic [DW-1:0]         rdata;
    logic                  refused;
    logic [NW-1:0][DW-1:0] cell_q;
    logic [DW-1:0]         rd;
    logic [DW-1:0]         snap;
    logic                  rf;
    int                    n_mismatch;
    int                    num_checks;

    rbac_bank rbac_bank_inst (
        .clk(clk), .resetn(resetn), .req(req), .we(we), .addr(addr),
        .wdata(wdata), .hw_in(hw_in), .ack(ack), .rdata(rdata),
        .refused(refused), .cell_q(cell_q)
    );

    always #4 clk = ~clk;

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task hw(input int w, input logic [DW-1:0] v);
        @(posedge clk);
        hw_in[w] <= v;
    endtask : hw

    // bounded wait; a missing ack ends the run rather than hanging it
    task wait_ack(input int s, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack[s] !== 1'b1 && n < 20);
        if (ack[s] !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_ack

    task access(input int s, input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        @(posedge clk);
        req[s]   <= 1'b1;
        we[s]    <= w;
        addr[s]  <= a;
        wdata[s] <= d;
        wait_ack(s, n);
        check(DW'(n), 16'h0002);
        rd = rdata;
        rf = refused;
        snap = cell_q[a];
        @(posedge clk);
        req[s] <= 1'b0;
        #1;
    endtask : access

    task scn_ro;
        hw(0, 16'hA5C3);
        tick(2);
        check(cell_q[0], 16'hA5C3);
        access(0, 1'b1, W_STAT, 16'h5A3C);
        tick(1);
        check(cell_q[0], 16'hA5C3);
        access(1, 1'b0, W_STAT, 16'h0000);
        check(rd, 16'hA5C3);
    endtask : scn_ro

    task scn_rdclr;
        hw(1, 16'h000A);
        hw(1, 16'h0000);
        tick(2);
        check(cell_q[1], 16'h000A);
        access(0, 1'b1, W_EVT, 16'h0F05);
        tick(1);
        check(cell_q[1], 16'h000A);
        access(2, 1'b0, W_EVT, 16'h0000);
        check(rd, 16'h000A);
        tick(1);
        check(cell_q[1], 16'h0000);
        access(2, 1'b0, W_EVT, 16'h0000);
        check(rd, 16'h0000);
    endtask : scn_rdclr

    task scn_wclr;
        hw(1, 16'h0FF0);
        hw(1, 16'h0000);
        tick(2);
        check(cell_q[1], 16'h0FF0);
        access(0, 1'b1, W_EVT, 16'h0A50);
        tick(1);
        check(cell_q[1], 16'h0AA0);
    endtask : scn_wclr

    task scn_self;
        access(0, 1'b1, W_EVT, 16'h3000);
        check(snap, 16'h30A0);
        check(cell_q[1], 16'h00A0);
        access(1, 1'b0, W_EVT, 16'h0000);
        check(rd, 16'h00A0);
    endtask : scn_self

    task scn_latch;
        hw(2, 16'h000F);
        access(0, 1'b1, W_LINK, 16'h9600);
        tick(1);
        check(cell_q[2] & 16'hFF00, 16'h9600);
        // this read also frees the latch-low bits taken while the condition sat low after reset
        access(0, 1'b0, W_LINK, 16'h0000);
        check(rd & 16'h0F00, 16'h0600);
        tick(2);
        check(cell_q[2] & 16'h00FF, 16'h000F);
        hw(2, 16'h00F0);
        hw(2, 16'h000F);
        tick(3);
        check(cell_q[2] & 16'h00FF, 16'h00F0);
        access(1, 1'b0, W_LINK, 16'h0000);
        check(rd & 16'h00FF, 16'h00F0);
        tick(2);
        check(cell_q[2] & 16'h00FF, 16'h000F);
    endtask : scn_latch

    task scn_src;
        for (int s = 0; s < NS; s++) begin
            access(s, 1'b1, W_LINK, {4'h0, 4'(s + 1), 8'h00});
            check({15'h0000, rf}, 16'h0000);
            tick(1);
            check(cell_q[2] & 16'h0F00, {4'h0, 4'(s + 1), 8'h00});
        end
        access(3, 1'b1, W_EVT, 16'hFFFF);
        check({15'h0000, rf}, 16'h0001);
        check(snap, 16'h00A0);
        access(3, 1'b0, W_STAT, 16'h0000);
        check({15'h0000, rf}, 16'h0001);
        check(rd, 16'h0000);
        access(0, 1'b1, W_RSVD, 16'h0000);
        check({15'h0000, rf}, 16'h0001);
        check(cell_q[3], 16'h0000);
        access(2, 1'b0, W_RSVD, 16'h0000);
        check(rd, 16'h0000);
    endtask : scn_src

    // two sources ask at once: lower index first, the other three cycles on
    task scn_prio;
        int n;
        @(posedge clk);
        req[1:0]  <= 2'b11;
        we[1:0]   <= 2'b00;
        addr[0]   <= W_STAT;
        addr[1]   <= W_LINK;
        wait_ack(0, n);
        check(DW'(ack), 16'h0001);
        check(rdata, 16'hA5C3);
        @(posedge clk);
        req[0] <= 1'b0;
        #1;
        wait_ack(1, n);
        check(DW'(n + 1), 16'h0003);
        @(posedge clk);
        req[1] <= 1'b0;
        #1;
    endtask : scn_prio

    // reset in mid-run clears every cell at once; the latch-low bits then
    // follow a high condition without any read
    task scn_reset;
        @(posedge clk);
        resetn <= 1'b0;
        tick(1);
        check(cell_q[0] | cell_q[2] | rdata, 16'h0000);
        @(posedge clk);
        resetn <= 1'b1;
        tick(4);
        check(cell_q[0], 16'hA5C3);
        check(cell_q[2], 16'h000F);
    endtask : scn_reset

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        req = '0;
        we = '0;
        addr = '0;
        wdata = '0;
        hw_in = '0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (20) @(posedge clk);
        #1;
        check(cell_q[1] | cell_q[2], 16'h0000);
        check(rdata | {15'h0000, refused} | DW'(ack), 16'h0000);
        @(posedge clk);
        resetn <= 1'b1;
        tick(4);
        scn_ro();
        scn_rdclr();
        scn_wclr();
        scn_self();
        scn_latch();
        scn_src();
        scn_prio();
        scn_reset();
        tick(2);
        print_verdict();
    end
endmodule : rbac_bank_tb_top
